// ==== phy_ctrl_consts.vh ====
// Purpose: Constants for the basic control register block.
// Assumes: 32-entry management register space, 16-bit registers.
// Notes: Definitions only.
`ifndef PHY_CTRL_CONSTS_VH
`define PHY_CTRL_CONSTS_VH
`define REG_ADDR_W 5
`define REG_DATA_W 16
`define REG_BASIC_CONTROL 5'h00
`define VENDOR_SPACE_BIT 4
`define BIT_SOFT_RESET 15
`define BIT_LOOPBACK 14
`define BIT_SPEED 13
`define BIT_AUTONEG_EN 12
`define BIT_POWER_DOWN 11
`define BIT_ISOLATE 10
`define BIT_AUTONEG_RESTART 9
`define BIT_DUPLEX 8
`define BIT_COL_TEST 7
`define RST_LOOPBACK 1'b0
`define RST_POWER_DOWN 1'b0
`define RST_ISOLATE 1'b0
`define RST_DUPLEX 1'b1
`define RST_COL_TEST 1'b0
`define RESERVED_READ 7'h00
`define SOFT_RESET_NS 40
`define CLK_PERIOD_NS 4
`define SOFT_RESET_CYCLES ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== pin_sync3.v ====
// Purpose: Three-stage synchroniser for a pin input.
// Assumes: Input is asynchronous to clk.
// Notes: A change is accepted once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 (
    input wire clk,
    input wire rst_n,
    input wire pin,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // pin_sync3
`default_nettype wire

// ==== phy_basic_control_register.v ====
// Purpose: Basic control register of a 10/100 Ethernet transceiver.
// Assumes: A management frame engine presents decoded register accesses.
// Notes: Only address 0 is implemented here; other addresses read zero.
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_consts.vh"
module phy_basic_control_register (
    input wire clk,
    input wire rst_n,
    input wire strap_negotiate_rate_pin,
    input wire reg_wr,
    input wire reg_rd,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output wire vendor_sel,
    input wire an_done,
    input wire an_speed_100,
    input wire an_full_duplex,
    output wire loopback_en,
    output wire power_down,
    output wire isolate,
    output wire col_test_en,
    output wire an_enable,
    output wire an_restart,
    output wire speed_100,
    output wire full_duplex,
    output wire soft_reset_active
);
    localparam integer RESET_CYCLES_I = `SOFT_RESET_CYCLES;
    localparam [7:0] RESET_CYCLES = RESET_CYCLES_I[7:0];
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_RESET = 2'h1;
    localparam [1:0] ST_LATCH = 2'h2;

    reg [1:0] state;
    reg [7:0] rst_count;
    reg strap_latched;
    reg loopback;
    reg speed_sel;
    reg an_en;
    reg pdown;
    reg iso;
    reg restart;
    reg duplex;
    reg col_test;
    wire strap_level;
    wire ctrl_hit;
    wire ctrl_wr;
    reg [15:0] next_rdata;
    wire [15:0] ctrl_view;
    wire [6:0] rsv_bits;
    genvar g;

    // five address bits cover both halves; the top bit picks the vendor half.
    function is_ctrl;
        input [4:0] a;
        begin
            is_ctrl = (a == `REG_BASIC_CONTROL);
        end
    endfunction

    pin_sync3 u_strap_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(strap_negotiate_rate_pin),
        .level(strap_level)
    );

    assign ctrl_hit = is_ctrl(reg_addr);
    assign ctrl_wr = reg_wr && ctrl_hit && (state == ST_RUN);
    assign vendor_sel = reg_addr[`VENDOR_SPACE_BIT];

    // Writes arriving during the internal reset are dropped so straps land cleanly.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // The strap syncer needs several edges after release, so a hardware
            // reset runs the same timed reset before the strap is latched.
            state <= ST_RESET;
            rst_count <= RESET_CYCLES;
            strap_latched <= 1'b0;
            loopback <= `RST_LOOPBACK;
            speed_sel <= 1'b0;
            an_en <= 1'b0;
            pdown <= `RST_POWER_DOWN;
            iso <= `RST_ISOLATE;
            restart <= 1'b0;
            duplex <= `RST_DUPLEX;
            col_test <= `RST_COL_TEST;
        end else begin
            restart <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (ctrl_wr) begin
                        if (reg_wdata[`BIT_SOFT_RESET] && pdown) begin
                            pdown <= 1'b0;
                        end else if (reg_wdata[`BIT_SOFT_RESET]) begin
                            state <= ST_RESET;
                            rst_count <= RESET_CYCLES;
                        end else begin
                            loopback <= reg_wdata[`BIT_LOOPBACK];
                            speed_sel <= reg_wdata[`BIT_SPEED];
                            an_en <= reg_wdata[`BIT_AUTONEG_EN];
                            pdown <= reg_wdata[`BIT_POWER_DOWN];
                            iso <= reg_wdata[`BIT_ISOLATE];
                            restart <= reg_wdata[`BIT_AUTONEG_RESTART];
                            duplex <= reg_wdata[`BIT_DUPLEX];
                            col_test <= reg_wdata[`BIT_COL_TEST];
                        end
                    end
                end
                ST_RESET: begin
                    loopback <= `RST_LOOPBACK;
                    pdown <= `RST_POWER_DOWN;
                    iso <= `RST_ISOLATE;
                    duplex <= `RST_DUPLEX;
                    col_test <= `RST_COL_TEST;
                    if (rst_count <= 8'h01) begin
                        state <= ST_LATCH;
                    end else begin
                        rst_count <= rst_count - 8'h01;
                    end
                end
                ST_LATCH: begin
                    strap_latched <= strap_level;
                    speed_sel <= strap_level;
                    an_en <= strap_level;
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    assign ctrl_view[`BIT_SOFT_RESET] = soft_reset_active;
    assign ctrl_view[`BIT_LOOPBACK] = loopback;
    assign ctrl_view[`BIT_SPEED] = speed_sel;
    assign ctrl_view[`BIT_AUTONEG_EN] = an_en;
    assign ctrl_view[`BIT_POWER_DOWN] = pdown;
    assign ctrl_view[`BIT_ISOLATE] = iso;
    assign ctrl_view[`BIT_AUTONEG_RESTART] = restart;
    assign ctrl_view[`BIT_DUPLEX] = duplex;
    assign ctrl_view[`BIT_COL_TEST] = col_test;

    assign rsv_bits = `RESERVED_READ;
    generate
        for (g = 0; g < `BIT_COL_TEST; g = g + 1) begin : g_rsv
            assign ctrl_view[g] = rsv_bits[g];
        end
    endgenerate

    // unmapped addresses read zero
    // Read data holds between reads so a slow controller can sample it late.
    always @* begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            if (ctrl_hit) begin
                next_rdata = ctrl_view;
            end else begin
                next_rdata = 16'h0000;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    assign loopback_en = loopback;
    assign power_down = pdown;
    assign isolate = iso;
    assign col_test_en = col_test;
    assign an_enable = an_en;
    assign an_restart = restart;
    assign speed_100 = an_en ? (an_done & an_speed_100) : speed_sel;
    assign full_duplex = an_en ? (an_done & an_full_duplex) : duplex;
    assign soft_reset_active = (state != ST_RUN);
endmodule // phy_basic_control_register
`default_nettype wire

// ==== phy_ctrl_props.sv ====
// Purpose: Port checker for the basic control register.
// Assumes: One clock, async active-low reset.
// Notes: Bound from tb_top.
`timescale 1ns/1ns
`default_nettype none
module phy_ctrl_props (
    input wire clk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire vendor_sel,
    input wire an_done,
    input wire an_speed_100,
    input wire an_full_duplex,
    input wire power_down,
    input wire an_enable,
    input wire an_restart,
    input wire speed_100,
    input wire full_duplex,
    input wire soft_reset_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Writes during a reset are dropped, so they are not causes.
    wire w0 = reg_wr && reg_addr == 5'h00 && !soft_reset_active;
    wire wr9 = w0 && reg_wdata[9] && !reg_wdata[15];
    sequence s_sr_run; soft_reset_active [*8]; endsequence
    property p_rsv; reg_rd && reg_addr == 5'h00 |=> reg_rdata[6:0] == 7'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_oth; reg_rd && reg_addr != 5'h00 |=> reg_rdata == 16'h0000; endproperty
    a_oth: assert property (p_oth) else $error("other address not zero");
    property p_vnd; reg_rd |-> vendor_sel == (reg_addr > 5'h0f); endproperty
    a_vnd: assert property (p_vnd) else $error("vendor half select");
    property p_sr; w0 && reg_wdata[15] && !power_down |=> s_sr_run ##[1:4] !soft_reset_active;
    endproperty
    a_sr: assert property (p_sr) else $error("soft reset length");
    property p_pd; w0 && reg_wdata[15] && power_down |=> !power_down && !soft_reset_active;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down exit");
    property p_an; wr9 |=> an_restart; endproperty
    a_an: assert property (p_an) else $error("no restart pulse");
    property p_an_src; an_restart |-> $past(wr9); endproperty
    a_an_src: assert property (p_an_src) else $error("stray restart");
    property p_spd; an_enable |-> speed_100 == (an_done && an_speed_100); endproperty
    a_spd: assert property (p_spd) else $error("speed override");
    property p_dup; an_enable |-> full_duplex == (an_done && an_full_duplex); endproperty
    a_dup: assert property (p_dup) else $error("duplex override");
endmodule // phy_ctrl_props
`default_nettype wire

// ==== mgmt_ctrl.sv ====
// Purpose: Management controller model issuing register accesses.
// Assumes: Decoded one-cycle strobes.
// Notes: Released lines carry inverted values so stale data is never trusted.
`timescale 1ns/1ns
`default_nettype none
module mgmt_ctrl (
    input wire clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire [15:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
    task wr(input [4:0] a, input [15:0] v);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    task rd(input [4:0] a, output [15:0] v);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        reg_addr <= ~a;
        @(negedge clk) v = reg_rdata;
    endtask
endmodule // mgmt_ctrl
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the basic control register.
// Assumes: The partner model issues all accesses.
// Notes: Strap changes only well before a reset so the syncer settles.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 0, rst_n = 0, strap_negotiate_rate_pin = 1;
    logic an_done = 1, an_speed_100 = 0, an_full_duplex = 1;
    logic reg_wr, reg_rd;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    wire vendor_sel, loopback_en, power_down, isolate, col_test_en, an_enable;
    wire an_restart, speed_100, full_duplex, soft_reset_active;
    int error_cnt = 0, n_checks = 0;
    phy_basic_control_register phy_basic_control_register_i (.*);
    mgmt_ctrl mgmt_ctrl_i (.*);
    initial forever #2 clk = ~clk;
    task close_out;
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input [15:0] g, input [15:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %0t got %h exp %h", $time, g, e);
        end
    endtask
    task srw;
        #1;
        for (int i = 0; i < 40 && soft_reset_active !== 0; i++) @(posedge clk);
        if (soft_reset_active !== 0) begin
            error_cnt++;
            close_out;
        end
    endtask
    task rc(input [15:0] e);
        mgmt_ctrl_i.rd(5'h00, d);
        chk(d, e);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (8) @(posedge clk);
        srw;
        rc(16'h3100);
        mgmt_ctrl_i.wr(5'h00, 16'h8000);
        srw;
        rc(16'h3100);
        mgmt_ctrl_i.wr(5'h00, 16'h64ff);
        #1 chk({loopback_en, isolate, col_test_en, speed_100, full_duplex}, 5'h1e);
        rc(16'h6480);
        mgmt_ctrl_i.wr(5'h00, 16'h1200);
        #1 chk({an_restart, speed_100, full_duplex}, 3'h5);
        rc(16'h1000);
        mgmt_ctrl_i.wr(5'h00, 16'h1800);
        #1 chk(power_down, 1);
        @(posedge clk) strap_negotiate_rate_pin <= 0;
        mgmt_ctrl_i.wr(5'h00, 16'h8000);
        #1 chk({power_down, soft_reset_active}, 0);
        rc(16'h1000);
        mgmt_ctrl_i.wr(5'h00, 16'h8000);
        srw;
        rc(16'h0100);
        mgmt_ctrl_i.wr(5'h05, 16'hffff);
        rc(16'h0100);
        mgmt_ctrl_i.rd(5'h11, d);
        chk(d, 0);
        close_out;
    end
endmodule // tb_top
bind phy_basic_control_register phy_ctrl_props phy_ctrl_props_i (.*);
`default_nettype wire
